// [common/cit_defs.svh]
// constants for the instruction timing sequencer
// assumes inclusion by bare name from each design file
`ifndef CIT_DEFS_SVH
`define CIT_DEFS_SVH

// system clock, the longest instruction, and byte and clock counts
`define CIT_CLK_MHZ      25
`define CIT_MAX_CYC      4'h8
`define CIT_ONE_CYC      4'h1
`define CIT_ONE_BYTE     2'h1
`define CIT_TWO_BYTE     2'h2
`define CIT_THREE_BYTE   2'h3
`define CIT_TWO_CYC      4'h2
`define CIT_THREE_CYC    4'h3
// program counter reset value and step
`define CIT_PC_RST       16'h0000
`define CIT_PC_STEP      16'h0001
// timing table entry: illegal, branch, bytes, cycles
`define CIT_E_ILL        7
`define CIT_E_BR         6
`define CIT_E_BYTES      5:4
`define CIT_E_CYC        3:0
// opcodes used by the checks
`define CIT_OP_DIV       8'h84
`define CIT_OP_NOP       8'h00

`endif

// [common/cit_pkg.sv]
// types for the instruction timing sequencer
// assumes cit_defs.svh is on the include path
package cit_pkg;

  // sequencer phases
  typedef enum logic [1:0] {
    CIT_S_OP   = 2'b00,
    CIT_S_ARG  = 2'b01,
    CIT_S_EXEC = 2'b10
  } cit_state_t;

  // whole state of the sequencer
  typedef struct packed {
    cit_state_t  state;
    logic [7:0]  op;
    logic [7:0]  arg1;
    logic [7:0]  arg2;
    logic [15:0] pc;
    logic [3:0]  cnt;
    logic [3:0]  base;
    logic [1:0]  nbytes;
    logic [1:0]  left;
    logic        br;
    logic        ext;
    logic        illegal;
    logic        ready;
    logic        start;
    logic        done;
    logic        halted;
    logic        hreq;
    logic        step;
    logic        skip;
  } cit_seq_t;

endpackage

// [core/cit_timing.sv]
// opcode timing lookup: length in bytes and clocks per opcode
// assumes a combinational consumer on the same clock
`timescale 1ns/1ps
`include "cit_defs.svh"

module cit_timing
  import cit_pkg::*;
(
  input  wire logic [7:0] op,
  output logic [1:0]      tim_bytes,
  output logic [3:0]      tim_cycles,
  output logic            tim_branch,
  output logic            tim_illegal
);

  // packed entry: {illegal, branch, bytes, cycles}
  function automatic logic [7:0] cit_entry(input logic [7:0] o);
    logic [3:0] hi;
    logic [7:0] e;
    hi = o[7:4];
    e  = 8'h11;
    unique case (o[3:0])
      4'h0: begin
        unique case (hi)
          4'h0:                      e = 8'h11;
          4'h1, 4'h2, 4'h3:          e = 8'h73;
          4'h4, 4'h5, 4'h6, 4'h7:    e = 8'h62;
          4'h8:                      e = 8'h23;
          4'h9:                      e = 8'h33;
          4'hA, 4'hB, 4'hC, 4'hD:    e = 8'h22;
          default:                   e = 8'h13;
        endcase
      end
      4'h1: e = 8'h23;
      4'h2: begin
        unique case (hi)
          4'h0, 4'h1:                e = 8'h34;
          4'h2, 4'h3:                e = 8'h15;
          4'hE, 4'hF:                e = 8'h13;
          default:                   e = 8'h22;
        endcase
      end
      4'h3: begin
        unique case (hi)
          4'h4, 4'h5, 4'h6:          e = 8'h33;
          // [RULE7] external data moves take three clocks
          4'h7, 4'h8, 4'h9,
          4'hE, 4'hF:                e = 8'h13;
          default:                   e = 8'h11;
        endcase
      end
      4'h4: begin
        unique case (hi)
          4'h0, 4'h1, 4'hC, 4'hD,
          4'hE, 4'hF:                e = 8'h11;
          4'h8:                      e = 8'h18;
          4'hA:                      e = 8'h14;
          4'hB:                      e = 8'h73;
          default:                   e = 8'h22;
        endcase
      end
      4'h5: begin
        unique case (hi)
          4'h7, 4'h8:                e = 8'h33;
          4'hA:                      e = 8'h91;
          4'hB:                      e = 8'h74;
          4'hD:                      e = 8'h73;
          default:                   e = 8'h22;
        endcase
      end
      4'h6, 4'h7: begin
        unique case (hi)
          4'h7, 4'h8, 4'hA:          e = 8'h22;
          4'hB:                      e = 8'h74;
          default:                   e = 8'h12;
        endcase
      end
      default: begin
        unique case (hi)
          4'h7, 4'h8, 4'hA:          e = 8'h22;
          4'hB:                      e = 8'h73;
          4'hD:                      e = 8'h62;
          default:                   e = 8'h11;
        endcase
      end
    endcase
    return e;
  endfunction

  // split the entry into its fields
  always_comb begin
    logic [7:0] e;
    e           = cit_entry(op);
    tim_illegal = e[`CIT_E_ILL];
    tim_branch  = e[`CIT_E_BR];
    tim_bytes   = e[`CIT_E_BYTES];
    tim_cycles  = e[`CIT_E_CYC];
  end

endmodule

// [core/cit_core_seq.sv]
// instruction timing sequencer with debug run control
// assumes a fetch unit and debug port logic on the same clock
`timescale 1ns/1ps
`include "cit_defs.svh"

// How it works
// [RULE1] durations count plain system clocks, no machine-cycle unit
// [RULE2] most instructions take one clock per program byte
// [RULE3] a conditional branch not taken finishes one clock earlier
// [RULE4] no instruction exceeds eight clocks; only divide uses eight
// [RULE5] encodings, addressing and status flags stay classic; timing differs
// [RULE6] the decoder knows exactly 109 distinct instructions
// [RULE7] clock counts per class follow the documented distribution
// [RULE8] accumulator with working register: one byte, one clock
// [RULE9] accumulator with direct byte: two bytes, two clocks
// [RULE10] accumulator with immediate: two bytes, two clocks
// [RULE11] indirect pointer register operand: one byte, two clocks
// [RULE12] immediate into direct byte logic: three bytes, three clocks
// [RULE13] accumulator into direct byte logic: two bytes, two clocks
// [RULE14] host sets breakpoints, halts, runs, steps and inspects state
// [RULE15] debug runs full speed using no program-visible resources
// [RULE16] programming and debug traffic arrive over the two-wire link; the code takes debug requests on plain input pins
// [RULE17] one program byte fetched per clock without stalls
module cit_core_seq
  import cit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  code_byte,
  input  wire logic        code_valid,
  input  wire logic        branch_taken,
  input  wire logic        dbg_halt_req,
  input  wire logic        dbg_run_req,
  input  wire logic        dbg_step_req,
  input  wire logic        bkpt_en,
  input  wire logic [15:0] bkpt_addr,
  output logic             code_ready,
  output logic [7:0]       op_code,
  output logic [7:0]       operand1,
  output logic [7:0]       operand2,
  output logic [15:0]      prog_ctr,
  output logic             instr_start,
  output logic             instr_done,
  output logic [3:0]       instr_cycles,
  output logic [1:0]       instr_bytes,
  output logic             instr_illegal,
  output logic             halted
);

  cit_seq_t   s_r;
  cit_seq_t   s_nxt;
  logic [1:0] tim_bytes;
  logic [3:0] tim_cycles;
  logic       tim_branch;
  logic       tim_illegal;
  logic       accept;
  logic       bp_hit;

  // per-opcode length and clock count
  // [RULE5] [RULE6] [RULE7] classic encodings, timing table in plain clocks
  cit_timing u_timing (
    .op          (code_byte),
    .tim_bytes   (tim_bytes),
    .tim_cycles  (tim_cycles),
    .tim_branch  (tim_branch),
    .tim_illegal (tim_illegal)
  );

  // true when this clock is the last of the instruction
  function automatic logic cit_last(input logic [3:0] cnt,
                                    input logic [3:0] base,
                                    input logic       br,
                                    input logic       tk);
    return (cnt == base && !(br && tk)) ||
           (cnt == base + `CIT_ONE_CYC);
  endfunction

  assign accept = s_r.ready && code_valid;

  // next state of the sequencer
  always_comb begin
    logic chk;
    chk         = 1'b0;
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    s_nxt.done  = 1'b0;
    unique case (s_r.state)
      // [RULE17] opcode byte taken in one clock
      CIT_S_OP: begin
        if (accept) begin
          s_nxt.op      = code_byte;
          s_nxt.arg1    = 8'h00;
          s_nxt.arg2    = 8'h00;
          s_nxt.pc      = s_r.pc + `CIT_PC_STEP;
          s_nxt.cnt     = `CIT_ONE_CYC;
          s_nxt.base    = tim_cycles;
          s_nxt.nbytes  = tim_bytes;
          s_nxt.left    = tim_bytes - `CIT_ONE_BYTE;
          s_nxt.br      = tim_branch;
          s_nxt.ext     = 1'b0;
          s_nxt.illegal = tim_illegal;
          s_nxt.start   = 1'b1;
          s_nxt.skip    = 1'b0;
          s_nxt.state   = (tim_bytes > `CIT_ONE_BYTE) ?
                          CIT_S_ARG : CIT_S_EXEC;
          chk           = (tim_bytes == `CIT_ONE_BYTE);
        end
      end
      // [RULE2] one operand byte per clock
      CIT_S_ARG: begin
        if (accept) begin
          if (s_r.left == s_r.nbytes - `CIT_ONE_BYTE) begin
            s_nxt.arg1 = code_byte;
          end else begin
            s_nxt.arg2 = code_byte;
          end
          s_nxt.pc   = s_r.pc + `CIT_PC_STEP;
          s_nxt.cnt  = s_r.cnt + `CIT_ONE_CYC;
          s_nxt.left = s_r.left - `CIT_ONE_BYTE;
          chk        = (s_r.left == `CIT_ONE_BYTE);
        end
      end
      // [RULE1] extra execute clocks, one count per clock
      CIT_S_EXEC: begin
        s_nxt.cnt = s_r.cnt + `CIT_ONE_CYC;
        chk       = 1'b1;
      end
      default: begin
        s_nxt.state = CIT_S_OP;
      end
    endcase
    // [RULE3] taken branch adds one clock
    if (chk) begin
      if (cit_last(s_nxt.cnt, s_nxt.base, s_nxt.br, branch_taken)) begin
        s_nxt.done  = 1'b1;
        s_nxt.state = CIT_S_OP;
      end else begin
        s_nxt.state = CIT_S_EXEC;
        if (s_nxt.br && branch_taken && s_nxt.cnt == s_nxt.base) begin
          s_nxt.ext = 1'b1;
        end
      end
    end
    // [RULE16] requests taken straight from dbg_run_req, dbg_step_req and dbg_halt_req inputs, no two-wire link
    // [RULE14] run and step release a halted core
    if (s_r.halted && dbg_run_req) begin
      s_nxt.halted = 1'b0;
      s_nxt.skip   = 1'b1;
    end else if (s_r.halted && dbg_step_req) begin
      s_nxt.halted = 1'b0;
      s_nxt.step   = 1'b1;
      s_nxt.skip   = 1'b1;
    end
    if (dbg_halt_req && !s_r.halted) begin
      s_nxt.hreq = 1'b1;
    end
    // [RULE14] halt only on an instruction boundary
    bp_hit = bkpt_en && (s_nxt.pc == bkpt_addr) && !s_nxt.skip;
    if (s_nxt.state == CIT_S_OP && !s_nxt.halted &&
        (s_nxt.hreq || bp_hit || (s_nxt.step && s_nxt.done))) begin
      s_nxt.halted = 1'b1;
      s_nxt.hreq   = 1'b0;
      s_nxt.step   = 1'b0;
    end
    // [RULE17] fetch offered whenever a byte is wanted
    s_nxt.ready = (s_nxt.state == CIT_S_ARG) ||
                  (s_nxt.state == CIT_S_OP && !s_nxt.halted);
  end

  // state register, private to debug and sequencing
  // [RULE15] no program-visible resource used
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.state   <= CIT_S_OP;
      s_r.pc      <= `CIT_PC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign code_ready    = s_r.ready;
  assign op_code       = s_r.op;
  assign operand1      = s_r.arg1;
  assign operand2      = s_r.arg2;
  assign prog_ctr      = s_r.pc;
  assign instr_start   = s_r.start;
  assign instr_done    = s_r.done;
  assign instr_cycles  = s_r.cnt;
  assign instr_bytes   = s_r.nbytes;
  assign instr_illegal = s_r.illegal;
  assign halted        = s_r.halted;

  // checks on the sequencer
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // opcode classes used by the checks
  logic alu_hi;
  logic op_rn;
  logic op_ind;
  logic op_dir;
  logic op_imm;
  assign alu_hi = (s_r.op[7:4] inside {4'h2, 4'h3, 4'h4,
                                       4'h5, 4'h6, 4'h9});
  assign op_rn  = alu_hi && s_r.op[3];
  assign op_ind = alu_hi && (s_r.op[3:1] == 3'h3);
  assign op_dir = alu_hi && (s_r.op[3:0] == 4'h5);
  assign op_imm = alu_hi && (s_r.op[3:0] == 4'h4);

  property p_max_cycles;
    instr_done |-> instr_cycles >= `CIT_ONE_CYC &&
                   instr_cycles <= `CIT_MAX_CYC;
  endproperty
  a_max_cycles: assert property (p_max_cycles) // [RULE4]
    else $error("instruction exceeded eight clocks");

  property p_div_eight;
    instr_start && op_code == `CIT_OP_DIV |->
      !instr_done [*7] ##1 (instr_done && instr_cycles == `CIT_MAX_CYC);
  endproperty
  a_div_eight: assert property (p_div_eight) // [RULE4]
    else $error("divide did not take eight clocks");

  property p_rn_one;
    instr_start && op_rn |-> instr_done && instr_bytes == `CIT_ONE_BYTE &&
                             instr_cycles == `CIT_ONE_CYC;
  endproperty
  a_rn_one: assert property (p_rn_one) // [RULE8]
    else $error("working register op not one clock");

  property p_dir_two;
    instr_done && op_dir |-> instr_bytes == `CIT_TWO_BYTE &&
                             instr_cycles == `CIT_TWO_CYC;
  endproperty
  a_dir_two: assert property (p_dir_two) // [RULE9]
    else $error("direct operand op not two clocks");

  property p_imm_two;
    instr_done && op_imm |-> instr_bytes == `CIT_TWO_BYTE &&
                             instr_cycles == `CIT_TWO_CYC;
  endproperty
  a_imm_two: assert property (p_imm_two) // [RULE10]
    else $error("immediate op not two clocks");

  property p_ind_two;
    instr_start && op_ind |-> !instr_done ##1
      (instr_done && instr_cycles == `CIT_TWO_CYC &&
       instr_bytes == `CIT_ONE_BYTE);
  endproperty
  a_ind_two: assert property (p_ind_two) // [RULE11]
    else $error("indirect op not one byte two clocks");

  property p_dir_logic;
    instr_done && s_r.op[7:4] inside {4'h4, 4'h5, 4'h6} |->
      (s_r.op[3:0] == 4'h3) ? instr_cycles == `CIT_THREE_CYC &&
                              instr_bytes == `CIT_THREE_BYTE :
      (s_r.op[3:0] == 4'h2) ? instr_cycles == `CIT_TWO_CYC &&
                              instr_bytes == `CIT_TWO_BYTE : 1'b1;
  endproperty
  a_dir_logic: assert property (p_dir_logic) // [RULE12] [RULE13]
    else $error("logic into direct byte has wrong timing");

  property p_branch_time;
    instr_done && s_r.br |->
      instr_cycles == s_r.base + {3'h0, s_r.ext};
  endproperty
  a_branch_time: assert property (p_branch_time) // [RULE3]
    else $error("branch length does not match taken state");

  property p_count_step;
    s_r.state == CIT_S_EXEC |=> s_r.cnt == $past(s_r.cnt) + `CIT_ONE_CYC;
  endproperty
  a_count_step: assert property (p_count_step) // [RULE1]
    else $error("clock count did not advance by one");

  // operand byte offered and address advances by one
  property p_arg_fetch;
    s_r.state == CIT_S_ARG && code_valid |->
      code_ready ##1 prog_ctr == $past(prog_ctr) + `CIT_PC_STEP;
  endproperty
  a_arg_fetch: assert property (p_arg_fetch) // [RULE17]
    else $error("operand fetch not offered");

  // step flag clears as the halt lands, so watch the finishing clock
  property p_step_halt;
    s_r.step && s_nxt.done |=> halted && instr_done && !code_ready;
  endproperty
  a_step_halt: assert property (p_step_halt) // [RULE14]
    else $error("single step did not halt after one instruction");

  property p_halt_quiet;
    halted |-> !code_ready ##1 !instr_start;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) // [RULE15]
    else $error("fetch while halted");

  c_div:   cover property (instr_done && op_code == `CIT_OP_DIV);
  c_taken: cover property (instr_done && s_r.br && s_r.ext);
  c_step:  cover property (s_r.step && s_nxt.done);
  c_bkpt:  cover property (halted && bkpt_en && prog_ctr == bkpt_addr);

endmodule

// [testbench/cit_code_src.sv]
// code store model feeding the sequencer one byte per clock, except for stall_cnt clocks at stall_at
// assumes prog_ctr addresses the next byte and drives at falling edge
`timescale 1ns/1ps

module cit_code_src (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic [15:0] prog_ctr,
  output logic [7:0]       code_byte,
  output logic             code_valid
);
  logic [7:0]  mem [0:255];
  logic [15:0] stall_at;
  int          stall_cnt;
  logic        hit;

  // store starts as single-clock no-ops
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    stall_at   = 16'h0001;
    stall_cnt  = 0;
    hit        = 1'b0;
    code_byte  = 8'h00;
    code_valid = 1'b0;
  end

  always @(negedge clk) begin
    hit = (prog_ctr == stall_at) && (stall_cnt > 0);
    if (hit)
      stall_cnt <= stall_cnt - 1;
    code_valid <= rst_n && en && !hit;
    // idle lines toggle so a stale byte never looks like code
    code_byte <= (rst_n && en && !hit) ? mem[prog_ctr[7:0]] : ~code_byte;
  end
endmodule

// [testbench/cpu_core_instruction_timing_tb.sv]
// self-checking bench for the instruction timing sequencer
// assumes cit_code_src as fetch side; inputs change at falling edge
`timescale 1ns/1ps

module cpu_core_instruction_timing_tb;
  import cit_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        en;
  logic        branch_taken;
  logic        dbg_halt_req;
  logic        dbg_run_req;
  logic        dbg_step_req;
  logic        bkpt_en;
  logic [15:0] bkpt_addr;
  logic [7:0]  code_byte;
  logic        code_valid;
  logic        code_ready;
  logic [7:0]  op_code;
  logic [7:0]  operand1;
  logic [7:0]  operand2;
  logic [15:0] prog_ctr;
  logic        instr_start;
  logic        instr_done;
  logic [3:0]  instr_cycles;
  logic [1:0]  instr_bytes;
  logic        instr_illegal;
  logic        halted;
  int          err_count;
  int          samples_checked;

  cit_core_seq dut_u (.clk(clk), .rst_n(rst_n), .code_byte(code_byte),
    .code_valid(code_valid), .branch_taken(branch_taken),
    .dbg_halt_req(dbg_halt_req), .dbg_run_req(dbg_run_req),
    .dbg_step_req(dbg_step_req), .bkpt_en(bkpt_en), .bkpt_addr(bkpt_addr),
    .code_ready(code_ready), .op_code(op_code), .operand1(operand1),
    .operand2(operand2), .prog_ctr(prog_ctr), .instr_start(instr_start),
    .instr_done(instr_done), .instr_cycles(instr_cycles),
    .instr_bytes(instr_bytes), .instr_illegal(instr_illegal),
    .halted(halted));

  cit_code_src src_u (.clk(clk), .rst_n(rst_n), .en(en),
    .prog_ctr(prog_ctr), .code_byte(code_byte), .code_valid(code_valid));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // reset held four clocks, fetch enabled afterwards
  task automatic do_reset();
    @(negedge clk);
    rst_n <= 1'b0;
    en    <= 1'b0;
    repeat (4) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    en <= 1'b1;
    chk("rst_ready", 16'(code_ready), 16'h0001);
    chk("rst_pc", prog_ctr, 16'h0000);
  endtask

  task automatic wait_flag(ref logic f, input int lim);
    int w;
    w = 0;
    while (f !== 1'b1 && w < lim) begin
      @(negedge clk);
      w++;
    end
  endtask

  task automatic count_done(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(negedge clk);
      if (instr_done === 1'b1)
        n++;
    end
  endtask

  // one instruction from address zero, span from start to done
  task automatic run_one(input logic [7:0] op, a1, a2, input logic [1:0] nb,
                         input logic [3:0] nc, input logic tk, input int st);
    int k;
    @(posedge clk);
    src_u.mem[0] = op;
    src_u.mem[1] = a1;
    src_u.mem[2] = a2;
    src_u.stall_cnt = st;
    do_reset();
    branch_taken <= tk;
    wait_flag(instr_start, 30);
    k = 1;
    while (instr_done !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("span", 16'(k), 16'(nc) + 16'(st));
    chk("cycles", 16'(instr_cycles), 16'(nc));
    chk("bytes", 16'(instr_bytes), 16'(nb));
    chk("opcode", 16'(op_code), 16'(op));
    chk("illegal", 16'(instr_illegal), 16'(op == 8'hA5));
    if (nb > 2'h1)
      chk("operand1", 16'(operand1), 16'(a1));
    if (nb > 2'h2)
      chk("operand2", 16'(operand2), 16'(a2));
  endtask

  // back-to-back stream: starts follow the previous lengths exactly
  task automatic seq_test();
    logic [7:0] prog [7] = '{8'h28, 8'h24, 8'h55, 8'h53, 8'h10, 8'h20, 8'h84};
    int         exp_st [5] = '{0, 1, 3, 6, 14};
    int         st [$];
    @(posedge clk);
    foreach (prog[i]) src_u.mem[i] = prog[i];
    do_reset();
    wait_flag(instr_start, 30);
    for (int c = 0; c < 16; c++) begin
      if (instr_start === 1'b1)
        st.push_back(c);
      @(negedge clk);
    end
    chk("starts", 16'(st.size() >= 5), 16'h0001);
    for (int i = 0; i < 5 && i < st.size(); i++)
      chk("start_at", 16'(st[i]), 16'(exp_st[i]));
  endtask

  // breakpoint, step, run and halt over a no-op stream
  task automatic dbg_test();
    int n;
    @(posedge clk);
    for (int i = 0; i < 16; i++) src_u.mem[i] = 8'h00;
    do_reset();
    bkpt_en   <= 1'b1;
    bkpt_addr <= 16'h0003;
    wait_flag(halted, 20);
    chk("bkpt_halt", 16'(halted), 16'h0001);
    chk("bkpt_pc", prog_ctr, 16'h0003);
    chk("bkpt_ready", 16'(code_ready), 16'h0000);
    count_done(4, n);
    chk("halted_done", 16'(n), 16'h0000);
    dbg_step_req <= 1'b1;
    @(negedge clk);
    dbg_step_req <= 1'b0;
    chk("step_go", 16'(halted), 16'h0000);
    wait_flag(instr_done, 10);
    chk("step_halt", 16'(halted), 16'h0001);
    chk("step_pc", prog_ctr, 16'h0004);
    dbg_run_req <= 1'b1;
    @(negedge clk);
    dbg_run_req <= 1'b0;
    chk("run_go", 16'(halted), 16'h0000);
    chk("run_ready", 16'(code_ready), 16'h0001);
    count_done(4, n);
    chk("run_rate", 16'(n >= 3), 16'h0001);
    dbg_halt_req <= 1'b1;
    @(negedge clk);
    dbg_halt_req <= 1'b0;
    wait_flag(halted, 4);
    chk("halt", 16'(halted), 16'h0001);
    count_done(4, n);
    chk("halt_done", 16'(n), 16'h0000);
    bkpt_en <= 1'b0;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #(40 * 5000);
    err_count++;
    final_report();
  end

  initial begin
    err_count       = 0;
    samples_checked = 0;
    rst_n           = 1'b0;
    en              = 1'b0;
    branch_taken    = 1'b0;
    dbg_halt_req    = 1'b0;
    dbg_run_req     = 1'b0;
    dbg_step_req    = 1'b0;
    bkpt_en         = 1'b0;
    bkpt_addr       = 16'h0000;
    seq_test();
    run_one(8'h28, 8'h00, 8'h00, 2'h1, 4'h1, 1'b0, 0);
    run_one(8'h25, 8'h30, 8'h00, 2'h2, 4'h2, 1'b0, 0);
    run_one(8'h24, 8'h5A, 8'h00, 2'h2, 4'h2, 1'b0, 0);
    run_one(8'h26, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 0);
    run_one(8'h53, 8'h40, 8'hC3, 2'h3, 4'h3, 1'b0, 0);
    run_one(8'h52, 8'h41, 8'h00, 2'h2, 4'h2, 1'b0, 0);
    run_one(8'h84, 8'h00, 8'h00, 2'h1, 4'h8, 1'b0, 0);
    run_one(8'hA4, 8'h00, 8'h00, 2'h1, 4'h4, 1'b0, 0);
    run_one(8'h22, 8'h00, 8'h00, 2'h1, 4'h5, 1'b0, 0);
    run_one(8'hE0, 8'h00, 8'h00, 2'h1, 4'h3, 1'b0, 0);
    run_one(8'hF3, 8'h00, 8'h00, 2'h1, 4'h3, 1'b0, 0);
    run_one(8'h40, 8'h10, 8'h00, 2'h2, 4'h2, 1'b0, 0);
    run_one(8'h40, 8'h10, 8'h00, 2'h2, 4'h3, 1'b1, 0);
    run_one(8'h20, 8'h21, 8'h05, 2'h3, 4'h3, 1'b0, 0);
    run_one(8'h20, 8'h21, 8'h05, 2'h3, 4'h4, 1'b1, 0);
    run_one(8'hB5, 8'h30, 8'hF0, 2'h3, 4'h4, 1'b0, 0);
    run_one(8'hB5, 8'h30, 8'hF0, 2'h3, 4'h5, 1'b1, 0);
    run_one(8'hA5, 8'h00, 8'h00, 2'h1, 4'h1, 1'b0, 0);
    run_one(8'h24, 8'h77, 8'h00, 2'h2, 4'h2, 1'b0, 3);
    dbg_test();
    final_report();
  end
endmodule
